// file: hdl/hmwc_pkg.sv
package hmwc_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] WAKE_CTRL_STATUS_OFS  = 8'h00;
	localparam logic [7:0] WAKE_PRESCALE_OFS     = 8'h04;
	localparam logic [7:0] MAIN_CLK_CTRL_OFS     = 8'h08;
	localparam logic [7:0] POWER_STATUS_OFS      = 8'h0c;

	// Field positions in wake_ctrl_status_reg
	localparam int AUTO_WAKE_ENABLE_BIT  = 0;
	localparam int WAKE_RC_MEASURE_BIT   = 1;
	localparam int WAKE_ELAPSED_FLAG_BIT = 2;

	// Field positions in main_clk_ctrl_status_reg
	localparam int TIMEBASE_IRQ_ENABLE_BIT = 0;

	// Field positions in the power status register
	localparam int STATE_LSB       = 0;
	localparam int STARTUP_BUSY_BIT = 4;
	localparam int WAKE_BY_RESET_BIT = 5;

	// Values after reset, and the forbidden prescale value
	localparam logic [2:0] WAKE_CTRL_RESET  = 3'h0;
	localparam logic [7:0] PRESCALE_RESET   = 8'hff;
	localparam logic [7:0] PRESCALE_FORBID  = 8'h00;
	localparam logic       TIMEBASE_RESET   = 1'b0;

	// Halt opcode and the mask level forced on halt entry
	localparam logic [7:0] HALT_OPCODE      = 8'h8e;
	localparam logic [1:0] MASK_LEVEL_HALT  = 2'h2;

	// Oscillator stabilisation counts in processor cycles
	localparam int          STARTUP_W       = 13;
	localparam logic [12:0] STARTUP_LONG    = 13'h1000;
	localparam logic [12:0] STARTUP_SHORT   = 13'h0100;

	// Fixed divider on the wake RC clock
	localparam int         WAKE_DIV_W       = 6;
	localparam logic [5:0] WAKE_DIV_LAST    = 6'h3f;

	// Power states
	typedef enum logic [2:0] {
		HMWC_RUN         = 3'b000,
		HMWC_HALT        = 3'b001,
		HMWC_ACTIVE_HALT = 3'b010,
		HMWC_TIMED_HALT  = 3'b011,
		HMWC_STARTUP     = 3'b100
	} hmwc_state_t;

endpackage

// file: hdl/hmwc_wake_timer.sv
module hmwc_wake_timer
	import hmwc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	input  wire logic       start,
	input  wire logic       run,
	input  wire logic       rc_tick,
	input  wire logic [7:0] prescale,
	output logic            elapsed
);

	logic [WAKE_DIV_W-1:0] div_cnt;
	logic [7:0]            pre_cnt;
	logic                  div_wrap;

	// One divided tick every 64 wake RC periods
	assign div_wrap = run && rc_tick && (div_cnt == WAKE_DIV_LAST);

	// Fixed divider, cleared on every entry so the first interval is whole
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			div_cnt <= '0;
		else if (clk_en)
		begin
			if (start)
				div_cnt <= '0;
			else if (run && rc_tick)
				div_cnt <= div_cnt + 6'h01;
		end
	end

	// Prescaler reloads from the programmed value on entry and counts down
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			pre_cnt <= PRESCALE_RESET;
		else if (clk_en)
		begin
			if (start)
				pre_cnt <= prescale;
			else if (div_wrap && pre_cnt != 8'h01)
				pre_cnt <= pre_cnt - 8'h01;
		end
	end

	// Terminal count of the prescaler ends the delay
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			elapsed <= 1'b0;
		else if (clk_en)
			elapsed <= !start && div_wrap && (pre_cnt == 8'h01);
	end

endmodule

// file: hdl/hmwc_halt_ctrl.sv
// Functional notes
// - Only halt-exit interrupts or reset leave halt
// - Push condition codes, load routine priority on service
// - Timebase enable picks plain or timebase-active halt
// - Timebase halt leaves on timebase, exit irq, reset
// - Reset exit from timebase halt waits startup count
// - Timebase halt entry forces mask 10b, pending wakes
// - Timebase halt keeps only oscillator and timebase clocked
// - Timebase halt enabled suppresses watchdog reset on halt
// - Auto wake without timebase enters timed wake halt
// - RC clock through divider and prescaler times delay
// - Delay end sets flag, irq, restarts oscillator, stabilises
// - Reading control status clears flag and wake irq
// - Measure mode routes RC clock to timer capture
// - Timed wake halt leaves on exit irq or reset
// - Timed wake halt entry forces mask 10b, pending wakes
// - Timed wake halt stops main oscillator and processing
// - Watchdog option decides reset instead of halt
// - Fixed divider divides the RC clock by 64
// - Prescaler divides by its value; zero is forbidden
//
// The address map and register access over APB were chosen for this implementation.
module hmwc_halt_ctrl
	import hmwc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        instr_valid,
	input  wire logic [7:0]  instr_opcode,
	input  wire logic        halt_exit_irq,
	input  wire logic        timebase_irq,
	input  wire logic [1:0]  irq_sw_priority,
	input  wire logic        reset_req,
	input  wire logic        watchdog_active,
	input  wire logic        opt_long_startup,
	input  wire logic        watchdog_halt_option,
	input  wire logic        wake_rc_clk,
	output logic             cpu_stall,
	output logic             mask_force,
	output logic [1:0]       irq_mask_level,
	output logic             ccr_push,
	output logic             core_restart,
	output logic             watchdog_reset_req,
	output logic             main_osc_en,
	output logic             periph_clk_en,
	output logic             timebase_clk_en,
	output logic             wake_rc_en,
	output logic             wake_irq,
	output logic             timer_capture_input_one
);

	hmwc_state_t          state;
	hmwc_state_t          next_state;
	logic [2:0]           pin_meta;
	logic [2:0]           pin_sync;
	logic                 rc_last;
	logic                 rc_tick;
	logic                 auto_wake_enable;
	logic                 wake_rc_measure;
	logic                 wake_elapsed_flag;
	logic                 timebase_irq_enable;
	logic [7:0]           wake_prescale_reg;
	logic [STARTUP_W-1:0] startup_cnt;
	logic                 wake_by_reset;
	logic                 timer_start;
	logic                 timer_elapsed;
	logic                 halt_cmd;
	logic                 wdg_trip;
	logic                 apb_access;
	logic                 apb_done;
	logic                 wr_done;
	logic                 rd_clear;
	logic                 addr_ok;
	logic [31:0]          rd_word;

	// Pin inputs: RC clock and option byte bits pass two flops before use
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pin_meta <= 3'h0;
			pin_sync <= 3'h0;
		end
		else if (clk_en)
		begin
			pin_meta <= {watchdog_halt_option, opt_long_startup, wake_rc_clk};
			pin_sync <= pin_meta;
		end
	end

	// Edge of the synchronised RC clock; only the second stage is looked at
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			rc_last <= 1'b0;
		else if (clk_en)
			rc_last <= pin_sync[0];
	end
	assign rc_tick = pin_sync[0] && !rc_last;

	// Halt is decoded from the opcode stream only in run
	assign halt_cmd = instr_valid && (instr_opcode == HALT_OPCODE) && (state == HMWC_RUN);

	// Watchdog reset replaces halt when the option asks, unless timebase halt is on
	assign wdg_trip = halt_cmd && watchdog_active && pin_sync[2] && !timebase_irq_enable;

	// Timer restarts on each entry into timed wake halt
	assign timer_start = halt_cmd && !wdg_trip && auto_wake_enable && !timebase_irq_enable;

	// Power state sequencing
	always_comb
	begin
		next_state = state;
		case (state)
			HMWC_RUN:
			begin
				if (halt_cmd && !wdg_trip)
				begin
					if (timebase_irq_enable)
						next_state = HMWC_ACTIVE_HALT;
					else if (auto_wake_enable)
						next_state = HMWC_TIMED_HALT;
					else
						next_state = HMWC_HALT;
				end
			end
			HMWC_HALT:
				// Other interrupt requests are not even looked at here
				if (halt_exit_irq || reset_req)
					next_state = HMWC_STARTUP;
			HMWC_ACTIVE_HALT:
			begin
				if (reset_req)
					next_state = HMWC_STARTUP;
				else if (timebase_irq || halt_exit_irq)
					next_state = HMWC_RUN;
			end
			HMWC_TIMED_HALT:
				if (timer_elapsed || halt_exit_irq || reset_req)
					next_state = HMWC_STARTUP;
			HMWC_STARTUP:
				if (startup_cnt == '0)
					next_state = HMWC_RUN;
			default:
				next_state = HMWC_RUN;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			state <= HMWC_RUN;
		else if (clk_en)
			state <= next_state;
	end

	// Remember why the oscillator restarted, to pick reset or service at the end
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			wake_by_reset <= 1'b0;
		else if (clk_en && state != HMWC_STARTUP && next_state == HMWC_STARTUP)
			wake_by_reset <= reset_req;
	end

	// Stabilisation counter; the option byte picks 4096 or 256 cycles
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			startup_cnt <= '0;
		else if (clk_en)
		begin
			if (state != HMWC_STARTUP && next_state == HMWC_STARTUP)
				startup_cnt <= pin_sync[1] ? STARTUP_LONG - 13'h0001 : STARTUP_SHORT - 13'h0001;
			else if (state == HMWC_STARTUP && startup_cnt != '0)
				startup_cnt <= startup_cnt - 13'h0001;
		end
	end

	// Mask forcing on entry, and priority loading when a wake interrupt is serviced
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mask_force     <= 1'b0;
			irq_mask_level <= MASK_LEVEL_HALT;
			ccr_push       <= 1'b0;
		end
		else if (clk_en)
		begin
			mask_force <= 1'b0;
			ccr_push   <= 1'b0;
			if (halt_cmd && !wdg_trip)
			begin
				mask_force     <= 1'b1;
				irq_mask_level <= MASK_LEVEL_HALT;
			end
			else if ((state == HMWC_ACTIVE_HALT && next_state == HMWC_RUN)
				|| (state == HMWC_STARTUP && next_state == HMWC_RUN && !wake_by_reset))
			begin
				// Core stacks the old codes and restores them on return
				ccr_push       <= 1'b1;
				mask_force     <= 1'b1;
				irq_mask_level <= irq_sw_priority;
			end
		end
	end

	// One-cycle requests to the core and to the watchdog
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			core_restart       <= 1'b0;
			watchdog_reset_req <= 1'b0;
		end
		else if (clk_en)
		begin
			core_restart       <= state == HMWC_STARTUP && next_state == HMWC_RUN && wake_by_reset;
			watchdog_reset_req <= wdg_trip;
		end
	end

	// Clock gating follows the next state so gates move with the transition
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cpu_stall       <= 1'b0;
			main_osc_en     <= 1'b1;
			periph_clk_en   <= 1'b1;
			timebase_clk_en <= 1'b1;
			wake_rc_en      <= 1'b0;
		end
		else if (clk_en)
		begin
			cpu_stall       <= next_state != HMWC_RUN;
			main_osc_en     <= next_state != HMWC_HALT && next_state != HMWC_TIMED_HALT;
			periph_clk_en   <= next_state == HMWC_RUN;
			timebase_clk_en <= next_state == HMWC_RUN || next_state == HMWC_ACTIVE_HALT;
			// RC oscillator is kept off when nothing needs it, to save power
			wake_rc_en      <= next_state == HMWC_TIMED_HALT
				|| (next_state == HMWC_RUN && wake_rc_measure);
		end
	end

	// Measurement path to the 16-bit timer capture, only in run
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			timer_capture_input_one <= 1'b0;
		else if (clk_en)
			timer_capture_input_one <= pin_sync[0] && wake_rc_measure && state == HMWC_RUN;
	end

	// Wake delay timer on the synchronised RC edges
	hmwc_wake_timer u_wake_timer (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.start    (timer_start),
		.run      (state == HMWC_TIMED_HALT),
		.rc_tick  (rc_tick),
		.prescale (wake_prescale_reg),
		.elapsed  (timer_elapsed)
	);

	// APB handshake: one wait cycle, answer registered
	assign apb_access = psel && penable && !pready;
	assign apb_done   = psel && penable && pready;
	assign wr_done    = apb_done && pwrite && !pslverr;
	assign rd_clear   = apb_done && !pwrite && !pslverr && (paddr == WAKE_CTRL_STATUS_OFS)
		&& prdata[WAKE_ELAPSED_FLAG_BIT];
	assign addr_ok    = paddr == WAKE_CTRL_STATUS_OFS || paddr == WAKE_PRESCALE_OFS
		|| paddr == MAIN_CLK_CTRL_OFS || paddr == POWER_STATUS_OFS;

	// Read mux; reserved bits read zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (paddr)
			WAKE_CTRL_STATUS_OFS:
				rd_word = {29'h0, wake_elapsed_flag, wake_rc_measure, auto_wake_enable};
			WAKE_PRESCALE_OFS:
				rd_word = {24'h0, wake_prescale_reg};
			MAIN_CLK_CTRL_OFS:
				rd_word = {31'h0, timebase_irq_enable};
			POWER_STATUS_OFS:
				rd_word = {26'h0, wake_by_reset, state == HMWC_STARTUP, 1'b0, state};
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready  <= apb_access;
			pslverr <= apb_access && !addr_ok;
			if (apb_access)
				prdata <= pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	// Software control bits
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			auto_wake_enable    <= WAKE_CTRL_RESET[AUTO_WAKE_ENABLE_BIT];
			wake_rc_measure     <= WAKE_CTRL_RESET[WAKE_RC_MEASURE_BIT];
			timebase_irq_enable <= TIMEBASE_RESET;
			wake_prescale_reg   <= PRESCALE_RESET;
		end
		else if (clk_en && wr_done)
		begin
			if (paddr == WAKE_CTRL_STATUS_OFS)
			begin
				auto_wake_enable <= pwdata[AUTO_WAKE_ENABLE_BIT];
				wake_rc_measure  <= pwdata[WAKE_RC_MEASURE_BIT];
			end
			if (paddr == MAIN_CLK_CTRL_OFS)
				timebase_irq_enable <= pwdata[TIMEBASE_IRQ_ENABLE_BIT];
			// A zero prescale is refused and the old value kept
			if (paddr == WAKE_PRESCALE_OFS && pwdata[7:0] != PRESCALE_FORBID)
				wake_prescale_reg <= pwdata[7:0];
		end
	end

	// Elapsed flag doubles as the wake interrupt; a new set beats the read clear
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			wake_elapsed_flag <= WAKE_CTRL_RESET[WAKE_ELAPSED_FLAG_BIT];
			wake_irq          <= 1'b0;
		end
		else if (clk_en)
		begin
			if (timer_elapsed)
			begin
				wake_elapsed_flag <= 1'b1;
				wake_irq          <= 1'b1;
			end
			else if (rd_clear)
			begin
				wake_elapsed_flag <= 1'b0;
				wake_irq          <= 1'b0;
			end
		end
	end

endmodule

// file: testbench/hmwc_core_model.sv
module hmwc_core_model
	import hmwc_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       halt_go,
	input  wire logic       cpu_stall,
	input  wire logic       ccr_push,
	input  wire logic       mask_force,
	input  wire logic [1:0] irq_mask_level,
	output logic            instr_valid,
	output logic [7:0]      instr_opcode,
	output logic [1:0]      core_mask,
	output logic [1:0]      stacked_mask
);
	timeunit 1ns;
	timeprecision 100ps;

	// Fetch stream; filler keeps bit 7 low so it can never look like a halt
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			instr_valid  <= 1'b0;
			instr_opcode <= 8'h00;
		end
		else
		begin
			instr_valid  <= !cpu_stall;
			instr_opcode <= halt_go ? HALT_OPCODE : {1'b0, instr_opcode[6:0] + 7'h01};
		end
	end

	// Mask register of the core; push keeps the level in force before service
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			core_mask    <= 2'h3;
			stacked_mask <= 2'h3;
		end
		else
		begin
			if (ccr_push)
				stacked_mask <= core_mask;
			if (mask_force)
				core_mask <= irq_mask_level;
		end
	end
endmodule

// file: testbench/hmwc_halt_ctrl_sva.sv
module hmwc_halt_ctrl_sva
	import hmwc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       cpu_stall,
	input wire logic       mask_force,
	input wire logic [1:0] irq_mask_level,
	input wire logic       ccr_push,
	input wire logic       core_restart,
	input wire logic       watchdog_reset_req,
	input wire logic       main_osc_en,
	input wire logic       periph_clk_en,
	input wire logic       timebase_clk_en,
	input wire logic       wake_irq,
	input wire logic       timer_capture_input_one,
	input wire logic       timebase_irq,
	input wire logic       halt_exit_irq,
	input wire logic       reset_req
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Halt entry and state relations seen at the ports
	a_entry_mask_forced: assert property ($rose(cpu_stall) |-> mask_force && irq_mask_level == MASK_LEVEL_HALT)
		else $error("halt entry without forced mask");
	a_osc_off_gates: assert property (cpu_stall && !main_osc_en |-> !periph_clk_en && !timebase_clk_en)
		else $error("clocks running with oscillator off");
	a_timebase_exit_fast: assert property (cpu_stall && main_osc_en && timebase_clk_en && !periph_clk_en
		&& timebase_irq && !reset_req |=> !cpu_stall && ccr_push)
		else $error("timebase halt not left at once");
	a_stopped_irq_exit: assert property (cpu_stall && !main_osc_en && halt_exit_irq |=> main_osc_en)
		else $error("exit interrupt did not restart oscillator");
	a_restart_in_run: assert property (core_restart |-> !cpu_stall && !ccr_push)
		else $error("restart pulse outside run");
	a_elapse_osc_on: assert property ($rose(wake_irq) |-> main_osc_en)
		else $error("wake flag without oscillator");
	a_trip_stays_run: assert property (watchdog_reset_req |-> !cpu_stall ##1 !cpu_stall && !watchdog_reset_req)
		else $error("watchdog trip left run");
	a_capture_run_only: assert property ($past(cpu_stall) |-> !timer_capture_input_one)
		else $error("capture driven while halted");
endmodule

// file: testbench/hmwc_halt_ctrl_tb.sv
`define CHK(a, e) \
	begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module hmwc_halt_ctrl_tb
	import hmwc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, halt_go = 1'b0, e;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0]  paddr = 8'h00, instr_opcode;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        halt_exit_irq = 1'b0, timebase_irq = 1'b0, reset_req = 1'b0, watchdog_active = 1'b0;
	logic        opt_long_startup = 1'b0, watchdog_halt_option = 1'b0, wake_rc_clk = 1'b0, instr_valid;
	logic [1:0]  irq_sw_priority = 2'h1, irq_mask_level, core_mask, stacked_mask;
	logic        cpu_stall, mask_force, ccr_push, core_restart, watchdog_reset_req, main_osc_en;
	logic        periph_clk_en, timebase_clk_en, wake_rc_en, wake_irq, timer_capture_input_one;
	int          fails = 0, samples_checked = 0, n;

	hmwc_halt_ctrl dut (
		.sys_clk                 (sys_clk),
		.sys_rst                 (sys_rst),
		.clk_en                  (clk_en),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.pready                  (pready),
		.prdata                  (prdata),
		.pslverr                 (pslverr),
		.instr_valid             (instr_valid),
		.instr_opcode            (instr_opcode),
		.halt_exit_irq           (halt_exit_irq),
		.timebase_irq            (timebase_irq),
		.irq_sw_priority         (irq_sw_priority),
		.reset_req               (reset_req),
		.watchdog_active         (watchdog_active),
		.opt_long_startup        (opt_long_startup),
		.watchdog_halt_option    (watchdog_halt_option),
		.wake_rc_clk             (wake_rc_clk),
		.cpu_stall               (cpu_stall),
		.mask_force              (mask_force),
		.irq_mask_level          (irq_mask_level),
		.ccr_push                (ccr_push),
		.core_restart            (core_restart),
		.watchdog_reset_req      (watchdog_reset_req),
		.main_osc_en             (main_osc_en),
		.periph_clk_en           (periph_clk_en),
		.timebase_clk_en         (timebase_clk_en),
		.wake_rc_en              (wake_rc_en),
		.wake_irq                (wake_irq),
		.timer_capture_input_one (timer_capture_input_one)
	);

	hmwc_core_model core (
		.sys_clk        (sys_clk),
		.sys_rst        (sys_rst),
		.halt_go        (halt_go),
		.cpu_stall      (cpu_stall),
		.ccr_push       (ccr_push),
		.mask_force     (mask_force),
		.irq_mask_level (irq_mask_level),
		.instr_valid    (instr_valid),
		.instr_opcode   (instr_opcode),
		.core_mask      (core_mask),
		.stacked_mask   (stacked_mask)
	);

	// Clocks; the RC source only oscillates while the block enables it
	always #20 sys_clk = ~sys_clk;
	always #98.7 wake_rc_clk = wake_rc_en & ~wake_rc_clk;

	task automatic summarize;
		$display("checks=%0d mismatches=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
		begin
			fails++;
			summarize();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(q, x);
	endtask

	// Halt request to the core; k cycles after it leaves the fetch
	task automatic halt(input int k);
		halt_go <= 1'b1;
		@(posedge sys_clk);
		halt_go <= 1'b0;
		cyc(k);
	endtask

	// Bounded wait for oscillator on (osc) or for run; n gets the cycles
	task automatic wait_for(input logic osc);
		n = 0;
		while ((osc ? main_osc_en : !cpu_stall) !== 1'b1 && n < 5000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 5000)
		begin
			fails++;
			summarize();
		end
	endtask

	initial
	begin
		cyc(8);
		sys_rst <= 1'b0;
		cyc(2);
		// Reset values, unmapped place, forbidden prescale
		rd(WAKE_CTRL_STATUS_OFS, 32'h0);
		rd(WAKE_PRESCALE_OFS, 32'hff);
		rd(MAIN_CLK_CTRL_OFS, 32'h0);
		rd(POWER_STATUS_OFS, 32'h0);
		rd(8'h10, 32'h0);
		`CHK(e, 1'b1);
		apb(1'b1, WAKE_PRESCALE_OFS, 32'h0);
		rd(WAKE_PRESCALE_OFS, 32'hff);
		// Timed wake: 64 x 2 RC edges, then short stabilisation
		apb(1'b1, WAKE_PRESCALE_OFS, 32'h2);
		apb(1'b1, WAKE_CTRL_STATUS_OFS, 32'h1);
		halt(3);
		`CHK({main_osc_en, periph_clk_en, wake_rc_en}, 3'b001);
		`CHK(core_mask, MASK_LEVEL_HALT);
		wait_for(1'b1);
		`CHK(n >= 615 && n <= 645, 1'b1);
		`CHK(wake_irq, 1'b1);
		wait_for(1'b0);
		`CHK(n >= 254 && n <= 258, 1'b1);
		cyc(1); // Core applies the push one edge after the pulse
		`CHK({core_mask, stacked_mask}, {irq_sw_priority, MASK_LEVEL_HALT});
		rd(WAKE_CTRL_STATUS_OFS, 32'h5);
		`CHK(wake_irq, 1'b0);
		rd(WAKE_CTRL_STATUS_OFS, 32'h1);
		// Plain halt ignores the timebase, leaves on exit irq after long start-up
		apb(1'b1, WAKE_CTRL_STATUS_OFS, 32'h0);
		opt_long_startup <= 1'b1;
		halt(3);
		`CHK({main_osc_en, timebase_clk_en, wake_rc_en}, 3'b000);
		timebase_irq <= 1'b1;
		cyc(1);
		timebase_irq <= 1'b0;
		cyc(4);
		`CHK(cpu_stall, 1'b1);
		halt_exit_irq <= 1'b1;
		cyc(1);
		halt_exit_irq <= 1'b0;
		wait_for(1'b0);
		`CHK(n >= 4095 && n <= 4100, 1'b1);
		// Timebase halt, watchdog armed: no trip, immediate exit on timebase
		opt_long_startup <= 1'b0;
		watchdog_active <= 1'b1;
		watchdog_halt_option <= 1'b1;
		apb(1'b1, MAIN_CLK_CTRL_OFS, 32'h1);
		halt(3);
		`CHK({cpu_stall, main_osc_en, timebase_clk_en, periph_clk_en}, 4'b1110);
		`CHK(core_mask, MASK_LEVEL_HALT);
		timebase_irq <= 1'b1;
		cyc(1);
		timebase_irq <= 1'b0;
		wait_for(1'b0);
		`CHK(n <= 2, 1'b1);
		// Timebase halt left by reset: short start-up and restart
		halt(3);
		reset_req <= 1'b1;
		cyc(1);
		reset_req <= 1'b0;
		wait_for(1'b0);
		`CHK(n >= 255 && n <= 260, 1'b1);
		`CHK(core_restart, 1'b1);
		rd(POWER_STATUS_OFS, 32'h20);
		// Watchdog trip replaces halt when timebase halt is off
		apb(1'b1, MAIN_CLK_CTRL_OFS, 32'h0);
		halt(2);
		`CHK(watchdog_reset_req, 1'b1);
		cyc(2);
		`CHK(cpu_stall, 1'b0);
		// Measurement routes the RC clock to the capture input in run
		`CHK(wake_rc_en, 1'b0);
		apb(1'b1, WAKE_CTRL_STATUS_OFS, 32'h2);
		q = 32'h0;
		repeat (40)
		begin
			@(posedge sys_clk);
			q[0] = q[0] | timer_capture_input_one;
			q[1] = q[1] | !timer_capture_input_one;
		end
		`CHK(q[1:0], 2'b11);
		summarize();
	end
endmodule

bind hmwc_halt_ctrl hmwc_halt_ctrl_sva chk (
	.sys_clk                 (sys_clk),
	.sys_rst                 (sys_rst),
	.cpu_stall               (cpu_stall),
	.mask_force              (mask_force),
	.irq_mask_level          (irq_mask_level),
	.ccr_push                (ccr_push),
	.core_restart            (core_restart),
	.watchdog_reset_req      (watchdog_reset_req),
	.main_osc_en             (main_osc_en),
	.periph_clk_en           (periph_clk_en),
	.timebase_clk_en         (timebase_clk_en),
	.wake_irq                (wake_irq),
	.timer_capture_input_one (timer_capture_input_one),
	.timebase_irq            (timebase_irq),
	.halt_exit_irq           (halt_exit_irq),
	.reset_req               (reset_req)
);
